// ---- inc/wmc_pkg.sv ----
package wmc_pkg;
  // clock and timing
  localparam int CLK_NS = 4;
  localparam int TE_NS = 400;
  localparam int TE_CYC = (TE_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEBOUNCE_NS = 20000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMR_W = 16;
  // shift register and frames
  localparam int SHIFT_W = 32;
  localparam int WORD_W = 16;
  localparam int BIT_CNT_W = 6;
  localparam logic [BIT_CNT_W-1:0] HDR_BITS = 6'h04;
  localparam logic [BIT_CNT_W-1:0] PROG_BITS = 6'h14;
  localparam logic [BIT_CNT_W-1:0] TX_BITS = 6'h20;
  // storage word map
  localparam int EE_AW = 3;
  localparam logic [EE_AW-1:0] EE_CFG = 3'h0;
  localparam logic [EE_AW-1:0] EE_CNT = 3'h1;
  localparam logic [EE_AW-1:0] EE_SEM = 3'h2;
  localparam logic [EE_AW-1:0] EE_USER0 = 3'h4;
  localparam logic [WORD_W-1:0] SEM_IDLE = 16'h0000;
  localparam logic [WORD_W-1:0] SEM_BUSY = 16'hA5A5;
  localparam logic [WORD_W-1:0] CFG_DEFAULT = 16'h0000;
  // configuration word fields
  localparam int CFG_OSC_LO = 0;
  localparam int CFG_PIN_SEL = 4;
  localparam int CFG_VLOW_SEL = 5;
  localparam int CFG_MOD_FMT = 6;
  localparam int CFG_RF_EN = 7;
  localparam logic [3:0] OSC_NOMINAL = 4'h0;
  localparam logic [4:0] OSC_SPAN = 5'h10;
  // bus register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_COUNTER = 8'h0C;
  localparam logic [7:0] REG_USER0 = 8'h10;
  localparam logic [7:0] REG_USER3 = 8'h1C;
  localparam logic [7:0] REG_SHIFT = 8'h20;
  localparam int CTRL_STANDBY = 0;
  localparam int CTRL_RELOAD = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // synchronised pin indices
  localparam int N_PIN = 7;
  localparam int P_BTN_A = 0;
  localparam int P_BTN_B = 1;
  localparam int P_MFP = 2;
  localparam int P_ANT = 3;
  localparam int P_DATA = 4;
  localparam int P_PROG = 5;
  localparam int P_VOK = 6;
  typedef enum logic [3:0] {
    ST_STANDBY = 4'h0,
    ST_WAKE = 4'h1,
    ST_CFG_LOAD = 4'h2,
    ST_SAMPLE = 4'h3,
    ST_SEM_SET = 4'h4,
    ST_CNT_WR = 4'h5,
    ST_SEM_CLR = 4'h6,
    ST_ENC_TX = 4'h7,
    ST_XPD = 4'h8,
    ST_PROG = 4'h9
  } wmc_state_e;
endpackage : wmc_pkg

// ---- design/wmc_wake_mode_config.sv ----
// How it works
// - after reset sit in low-power standby
// - button high or antenna signal wakes logic
// - after wake, sample inputs for wake source
// - button wake selects encoder mode
// - antenna wake selects transponder mode
// - buttons win; antenna waits for release
// - one FSM, two timers, one 32-bit shifter
// - four 16-bit user words, link and programmer
// - counter kept gray, one-bit writes, sent binary
// - semaphore guards counter; write needs voltage OK
// - programmer clocks data on multi-function pin
// - first activation loads configuration word
// - configuration steers tune, pin, trip, format
// - tune 0 nominal, 1-7 slower, 8-F faster
// - multi-function pin role follows configuration
// - data pin sends stream or programming data
// - antenna pin receives and drives responses
// - select 0 antenna, 1 button or RF enable
// - before load, pin acts as antenna input
module wmc_wake_mode_config #(
  parameter int DEBOUNCE_CYCLES = wmc_pkg::DEBOUNCE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic button_in_a_i,
  input wire logic button_in_b_i,
  input wire logic multi_function_pin_i,
  input wire logic antenna_sense_pin_i,
  input wire logic data_pin_i,
  input wire logic prog_enable_i,
  input wire logic write_voltage_ok_i,
  output logic main_power_o,
  output logic encoder_mode_o,
  output logic transponder_mode_o,
  output logic data_pin_o,
  output logic data_pin_oe_o,
  output logic multi_function_pin_o,
  output logic multi_function_pin_oe_o,
  output logic antenna_sense_en_o,
  output logic antenna_drive_pin_o,
  output logic osc_slow_o,
  output logic osc_fast_o,
  output logic [3:0] osc_step_o,
  output logic vlow_select_o,
  output logic mod_format_o,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // pin synchronisers: three stages, a change counts when stages two and three agree
  logic [wmc_pkg::N_PIN-1:0] pin_raw; // raw pins
  logic [wmc_pkg::N_PIN-1:0] sync1; // first stage, read by sync2 only
  logic [wmc_pkg::N_PIN-1:0] sync2;
  logic [wmc_pkg::N_PIN-1:0] sync3;
  logic [wmc_pkg::N_PIN-1:0] pin_f; // filtered levels
  assign pin_raw = {write_voltage_ok_i, prog_enable_i, data_pin_i, antenna_sense_pin_i,
                    multi_function_pin_i, button_in_b_i, button_in_a_i};

  genvar gi;
  generate
    for (gi = 0; gi < wmc_pkg::N_PIN; gi++) begin : g_sync
      // pull-down pins read low from reset
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
          pin_f[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
          if (sync2[gi] == sync3[gi]) begin
            pin_f[gi] <= sync3[gi];
          end
        end
      end
    end
  endgenerate

  // storage array: configuration, counter, semaphore, user words
  logic [wmc_pkg::WORD_W-1:0] ee_mem [0:(1 << wmc_pkg::EE_AW)-1];
  logic [wmc_pkg::WORD_W-1:0] cfg; // configuration register
  logic cfg_valid; // cleared at supply-on, set after load
  wmc_pkg::wmc_state_e state;
  wmc_pkg::wmc_state_e next_state;
  logic [wmc_pkg::TMR_W-1:0] timer; // debounce timer
  logic [wmc_pkg::SHIFT_W-1:0] shifter; // shared 32-bit shift register
  logic [wmc_pkg::BIT_CNT_W-1:0] bit_cnt;
  logic [wmc_pkg::TMR_W-1:0] te_div; // basic_timing_element divider
  logic te_tick;
  logic mfp_prev; // filtered programming clock, last cycle
  logic [3:0] wake_status; // {antenna, c, b, a} seen at sampling

  // decoding of pins and configuration
  wire pin_sel_eff = cfg_valid & cfg[wmc_pkg::CFG_PIN_SEL];
  wire btn_c = pin_sel_eff & pin_f[wmc_pkg::P_MFP];
  wire any_btn = pin_f[wmc_pkg::P_BTN_A] | pin_f[wmc_pkg::P_BTN_B] | btn_c;
  wire ant_on = ~pin_sel_eff & pin_f[wmc_pkg::P_ANT];
  wire prog_on = pin_f[wmc_pkg::P_PROG];
  wire vok = pin_f[wmc_pkg::P_VOK];
  wire prog_rise = pin_f[wmc_pkg::P_MFP] & ~mfp_prev;
  wire [wmc_pkg::WORD_W-1:0] cnt_gray = ee_mem[wmc_pkg::EE_CNT];
  wire [3:0] osc_val = cfg[wmc_pkg::CFG_OSC_LO +: 4];

  // gray to binary and the next gray value
  function automatic logic [wmc_pkg::WORD_W-1:0] gray2bin(input logic [wmc_pkg::WORD_W-1:0] g);
    logic [wmc_pkg::WORD_W-1:0] b;
    b[wmc_pkg::WORD_W-1] = g[wmc_pkg::WORD_W-1];
    for (int k = wmc_pkg::WORD_W - 2; k >= 0; k--) begin
      b[k] = b[k+1] ^ g[k];
    end
    return b;
  endfunction : gray2bin
  wire [wmc_pkg::WORD_W-1:0] cnt_bin = gray2bin(cnt_gray);
  wire [wmc_pkg::WORD_W-1:0] cnt_bin_inc = cnt_bin + 16'h0001;
  wire [wmc_pkg::WORD_W-1:0] cnt_gray_nx = cnt_bin_inc ^ (cnt_bin_inc >> 1);
  // only one bit changes per step, so only that bit is rewritten
  wire [wmc_pkg::WORD_W-1:0] cnt_flip = cnt_gray ^ cnt_gray_nx;

  // programming header bits
  wire prog_is_wr = shifter[wmc_pkg::WORD_W + 2];
  wire [wmc_pkg::EE_AW-1:0] prog_addr = shifter[wmc_pkg::WORD_W - 1 +: wmc_pkg::EE_AW];
  logic prog_rd; // device drives data pin

  // bus handshake state
  logic [7:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic w_full;
  wire bus_wr = aw_full & w_full & ~s_axi_bvalid;
  wire wr_user = (aw_addr >= wmc_pkg::REG_USER0) && (aw_addr <= wmc_pkg::REG_USER3);
  wire wr_ctrl = (aw_addr == wmc_pkg::REG_CTRL);
  wire wr_cfg = (aw_addr == wmc_pkg::REG_CONFIG);
  wire wr_ok = wr_user | wr_ctrl | wr_cfg;
  wire [wmc_pkg::EE_AW-1:0] user_idx = wmc_pkg::EE_USER0 + wmc_pkg::EE_AW'(aw_addr[3:2]);
  wire sw_standby = bus_wr & wr_ctrl & w_data[wmc_pkg::CTRL_STANDBY];
  wire sw_reload = bus_wr & wr_ctrl & w_data[wmc_pkg::CTRL_RELOAD];

  // one storage write port; machine and programmer beat the bus
  logic ee_we;
  logic [wmc_pkg::EE_AW-1:0] ee_addr;
  logic [wmc_pkg::WORD_W-1:0] ee_wdata;
  wire fsm_wr = vok & ((state == wmc_pkg::ST_SEM_SET) | (state == wmc_pkg::ST_CNT_WR) |
                       (state == wmc_pkg::ST_SEM_CLR));
  wire prog_wr = (state == wmc_pkg::ST_PROG) & prog_rise & prog_is_wr &
                 (bit_cnt == wmc_pkg::PROG_BITS - 6'h01);
  assign ee_we = fsm_wr | prog_wr | (bus_wr & (wr_user | wr_cfg));
  assign ee_addr = (state == wmc_pkg::ST_CNT_WR) ? wmc_pkg::EE_CNT :
                   fsm_wr ? wmc_pkg::EE_SEM :
                   prog_wr ? prog_addr :
                   wr_cfg ? wmc_pkg::EE_CFG : user_idx;
  assign ee_wdata = (state == wmc_pkg::ST_SEM_SET) ? wmc_pkg::SEM_BUSY :
                    (state == wmc_pkg::ST_SEM_CLR) ? wmc_pkg::SEM_IDLE :
                    (state == wmc_pkg::ST_CNT_WR) ? (cnt_gray ^ cnt_flip) :
                    prog_wr ? {shifter[wmc_pkg::WORD_W-2:0], pin_f[wmc_pkg::P_DATA]} :
                    w_data[wmc_pkg::WORD_W-1:0];

  // storage: contents survive reset, as nonvolatile cells would
  always_ff @(posedge mclk_i) begin
    if (ee_we) begin
      ee_mem[ee_addr] <= ee_wdata;
    end
  end

  // next-state logic; one machine runs every mode
  always_comb begin
    next_state = state;
    case (state)
      wmc_pkg::ST_STANDBY: begin
        if (prog_on) begin
          next_state = wmc_pkg::ST_PROG;
        end else if (any_btn | ant_on) begin
          next_state = wmc_pkg::ST_WAKE;
        end
      end
      wmc_pkg::ST_WAKE: begin
        if (timer == '0) begin
          next_state = cfg_valid ? wmc_pkg::ST_SAMPLE : wmc_pkg::ST_CFG_LOAD;
        end
      end
      wmc_pkg::ST_CFG_LOAD: next_state = wmc_pkg::ST_SAMPLE;
      wmc_pkg::ST_SAMPLE: begin
        if (any_btn) begin
          next_state = wmc_pkg::ST_SEM_SET;
        end else if (ant_on) begin
          next_state = wmc_pkg::ST_XPD;
        end else begin
          next_state = wmc_pkg::ST_STANDBY;
        end
      end
      wmc_pkg::ST_SEM_SET: if (vok) next_state = wmc_pkg::ST_CNT_WR;
      wmc_pkg::ST_CNT_WR: if (vok) next_state = wmc_pkg::ST_SEM_CLR;
      wmc_pkg::ST_SEM_CLR: if (vok) next_state = wmc_pkg::ST_ENC_TX;
      wmc_pkg::ST_ENC_TX: begin
        // a frame completes unless a standby command ends it; repeat while any button stays pressed
        if (te_tick && bit_cnt == wmc_pkg::TX_BITS - 6'h01 && !any_btn) begin
          next_state = wmc_pkg::ST_STANDBY;
        end
      end
      wmc_pkg::ST_XPD: begin
        if (any_btn) begin
          next_state = wmc_pkg::ST_WAKE;
        end else if (!ant_on) begin
          next_state = wmc_pkg::ST_STANDBY;
        end
      end
      wmc_pkg::ST_PROG: if (!prog_on) next_state = wmc_pkg::ST_STANDBY;
      default: next_state = wmc_pkg::ST_STANDBY;
    endcase
    if (sw_standby && state != wmc_pkg::ST_PROG) begin
      next_state = wmc_pkg::ST_STANDBY;
    end
  end

  // state register and configuration; reset stands for supply connection
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= wmc_pkg::ST_STANDBY;
      cfg <= wmc_pkg::CFG_DEFAULT;
      cfg_valid <= 1'b0;
    end else begin
      state <= next_state;
      if (state == wmc_pkg::ST_CFG_LOAD || sw_reload) begin
        cfg <= ee_mem[wmc_pkg::EE_CFG];
        cfg_valid <= 1'b1;
      end
    end
  end

  // timers: debounce count on entry to wake, separate basic timing element divider in every state
  assign te_tick = (te_div == '0);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      timer <= '0;
      te_div <= '0;
    end else begin
      timer <= (state != wmc_pkg::ST_WAKE) ? wmc_pkg::TMR_W'(DEBOUNCE_CYCLES - 1) :
               (timer - 16'h0001);
      // restart before a frame so its first bit lasts a full element
      te_div <= (te_tick || state == wmc_pkg::ST_SEM_CLR) ?
                wmc_pkg::TMR_W'(wmc_pkg::TE_CYC - 1) : (te_div - 16'h0001);
    end
  end

  // shift register and bit counter, shared by encoder, transponder and programmer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      shifter <= '0;
      bit_cnt <= '0;
      mfp_prev <= 1'b0;
      wake_status <= 4'h0;
      prog_rd <= 1'b0;
    end else begin
      mfp_prev <= pin_f[wmc_pkg::P_MFP];
      if (state == wmc_pkg::ST_SAMPLE) begin
        wake_status <= {ant_on, btn_c, pin_f[wmc_pkg::P_BTN_B], pin_f[wmc_pkg::P_BTN_A]};
        bit_cnt <= '0;
        prog_rd <= 1'b0;
        shifter <= {ee_mem[wmc_pkg::EE_USER0], ee_mem[wmc_pkg::EE_USER0 + 3'h1]};
      end else if (state == wmc_pkg::ST_SEM_CLR) begin
        shifter <= {cnt_bin, 12'h000, wake_status};
        bit_cnt <= '0;
      end else if ((state == wmc_pkg::ST_ENC_TX || state == wmc_pkg::ST_XPD) && te_tick) begin
        if (state == wmc_pkg::ST_ENC_TX && bit_cnt == wmc_pkg::TX_BITS - 6'h01) begin
          shifter <= {cnt_bin, 12'h000, wake_status}; // reload for repeat frame
          bit_cnt <= '0;
        end else begin
          shifter <= {shifter[wmc_pkg::SHIFT_W-2:0], shifter[wmc_pkg::SHIFT_W-1]};
          bit_cnt <= bit_cnt + 6'h01;
        end
      end else if (state == wmc_pkg::ST_PROG && prog_rise) begin
        if (prog_rd) begin
          shifter <= {shifter[wmc_pkg::SHIFT_W-2:0], 1'b0};
        end else if (bit_cnt == wmc_pkg::HDR_BITS - 6'h01 && !shifter[2]) begin
          // read header complete: load addressed word for shifting out
          shifter <= {ee_mem[{shifter[1:0], pin_f[wmc_pkg::P_DATA]}], 16'h0000};
          prog_rd <= 1'b1;
        end else begin
          shifter <= {shifter[wmc_pkg::SHIFT_W-2:0], pin_f[wmc_pkg::P_DATA]};
        end
        if (bit_cnt == wmc_pkg::PROG_BITS - 6'h01) begin
          bit_cnt <= '0;
          prog_rd <= 1'b0;
        end else begin
          bit_cnt <= bit_cnt + 6'h01;
        end
      end else if (state != wmc_pkg::ST_PROG && state != wmc_pkg::ST_ENC_TX &&
                   state != wmc_pkg::ST_XPD) begin
        bit_cnt <= '0;
        prog_rd <= 1'b0;
      end
    end
  end

  // pin and mode outputs, all registered
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      main_power_o <= 1'b0;
      encoder_mode_o <= 1'b0;
      transponder_mode_o <= 1'b0;
      data_pin_o <= 1'b0;
      data_pin_oe_o <= 1'b0;
      multi_function_pin_o <= 1'b0;
      multi_function_pin_oe_o <= 1'b0;
      antenna_sense_en_o <= 1'b1;
      antenna_drive_pin_o <= 1'b0;
      osc_slow_o <= 1'b0;
      osc_fast_o <= 1'b0;
      osc_step_o <= 4'h0;
      vlow_select_o <= 1'b0;
      mod_format_o <= 1'b0;
    end else begin
      main_power_o <= (state != wmc_pkg::ST_STANDBY);
      encoder_mode_o <= (state == wmc_pkg::ST_ENC_TX);
      transponder_mode_o <= (state == wmc_pkg::ST_XPD);
      // data pin: stream in encoder mode, read data in programming
      data_pin_oe_o <= (state == wmc_pkg::ST_ENC_TX) | (state == wmc_pkg::ST_PROG & prog_rd);
      data_pin_o <= ((state == wmc_pkg::ST_ENC_TX) | prog_rd) & shifter[wmc_pkg::SHIFT_W-1];
      // multi-function pin drives only as RF enable; programming clock is an input
      multi_function_pin_oe_o <= pin_sel_eff & cfg[wmc_pkg::CFG_RF_EN] &
                                 (state != wmc_pkg::ST_PROG);
      multi_function_pin_o <= pin_sel_eff & cfg[wmc_pkg::CFG_RF_EN] &
                              (state == wmc_pkg::ST_ENC_TX);
      antenna_sense_en_o <= ~pin_sel_eff;
      antenna_drive_pin_o <= ~pin_sel_eff & (state == wmc_pkg::ST_XPD) &
                             shifter[wmc_pkg::SHIFT_W-1];
      // tune decode: low half slower except 0000, high half faster, 1000 fastest
      osc_slow_o <= ~osc_val[3] & (osc_val != wmc_pkg::OSC_NOMINAL);
      osc_fast_o <= osc_val[3];
      osc_step_o <= osc_val[3] ? 4'(wmc_pkg::OSC_SPAN - {1'b0, osc_val}) : osc_val;
      vlow_select_o <= cfg[wmc_pkg::CFG_VLOW_SEL];
      mod_format_o <= cfg[wmc_pkg::CFG_MOD_FMT];
    end
  end

  // read data decode
  logic [31:0] rd_data;
  logic rd_hit;
  wire [7:0] ar = s_axi_araddr[7:0];
  wire ar_user = (ar >= wmc_pkg::REG_USER0) && (ar <= wmc_pkg::REG_USER3);
  wire [wmc_pkg::EE_AW-1:0] ar_idx = wmc_pkg::EE_USER0 + wmc_pkg::EE_AW'(ar[3:2]);
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (s_axi_araddr[31:8] != 24'h000000 || ar[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end else if (ar == wmc_pkg::REG_CTRL) begin
      rd_data = 32'h0000_0000; // command bits are pulses
    end else if (ar == wmc_pkg::REG_STATUS) begin
      rd_data = {21'h000000, wake_status, cfg_valid, 2'h0, state};
    end else if (ar == wmc_pkg::REG_CONFIG) begin
      rd_data = {16'h0000, cfg};
    end else if (ar == wmc_pkg::REG_COUNTER) begin
      rd_data = {16'h0000, cnt_bin};
    end else if (ar_user) begin
      rd_data = {16'h0000, ee_mem[ar_idx]};
    end else if (ar == wmc_pkg::REG_SHIFT) begin
      rd_data = shifter;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // AXI4-Lite slave: one write and one read in flight, unmapped answers SLVERR
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wmc_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= wmc_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_full & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_full & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full <= 1'b1;
        // high address bits must be zero, else the write misses
        aw_addr <= (s_axi_awaddr[31:8] == 24'h000000) ? s_axi_awaddr[7:0] : 8'hFF;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata; // whole-word registers; strobes not used
      end
      if (bus_wr) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? wmc_pkg::RESP_OKAY : wmc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? wmc_pkg::RESP_OKAY : wmc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : wmc_wake_mode_config

// ---- test/wmc_wake_mode_config_assertions.sv ----
module wmc_wake_mode_config_checker (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic main_power_o,
  input wire logic encoder_mode_o,
  input wire logic transponder_mode_o,
  input wire logic multi_function_pin_oe_o,
  input wire logic antenna_sense_en_o,
  input wire logic osc_slow_o,
  input wire logic osc_fast_o,
  input wire logic [3:0] osc_step_o,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock domain
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_standby_quiet:
    assert property (!main_power_o |-> !encoder_mode_o && !transponder_mode_o)
    else $error("mode active while in standby");
  chk_mode_single:
    assert property (!(encoder_mode_o && transponder_mode_o))
    else $error("encoder and transponder mode together");
  chk_tune_dir:
    assert property (!(osc_slow_o && osc_fast_o))
    else $error("tune both slower and faster");
  chk_slow_step:
    assert property (osc_slow_o |-> osc_step_o inside {[4'h1:4'h7]})
    else $error("slow tune step out of range");
  chk_fast_step:
    assert property (osc_fast_o |-> osc_step_o inside {[4'h1:4'h8]})
    else $error("fast tune step out of range");
  chk_rf_pin_sense:
    assert property (multi_function_pin_oe_o |-> !antenna_sense_en_o)
    else $error("rf enable driven with antenna input on");
  chk_xpd_sense:
    assert property (transponder_mode_o |-> antenna_sense_en_o)
    else $error("transponder mode without antenna input");
  chk_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_write_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
endmodule : wmc_wake_mode_config_checker

bind wmc_wake_mode_config wmc_wake_mode_config_checker chk_u (.mclk_i, .rst_i, .main_power_o,
  .encoder_mode_o, .transponder_mode_o, .multi_function_pin_oe_o, .antenna_sense_en_o,
  .osc_slow_o, .osc_fast_o, .osc_step_o, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready);

// ---- test/wmc_prog_model.sv ----
module wmc_prog_model (
  input wire logic mclk_i,
  input wire logic dev_data_i,
  input wire logic dev_oe_i,
  output logic prog_clk_o,
  output logic prog_en_o,
  output logic data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv = 1'b0; // programmer drives the data line
  logic val = 1'b0; // level it drives
  logic last = 1'b0; // last level on the line
  initial {prog_clk_o, prog_en_o} = 2'b00;
  // undriven line toggles, so stale data cannot pass
  assign data_o = dev_oe_i ? dev_data_i : (drv ? val : !last);
  always @(posedge mclk_i) last <= data_o;
  // frame: {wr, addr} header, 16 data bits, slow clock for the pin filter
  task automatic frame(input logic [19:0] f, output logic [15:0] rd);
    prog_en_o <= 1'b1;
    for (int i = 19; i >= 0; i--) begin
      drv <= f[19] || i > 15;
      val <= f[i];
      repeat (12) @(posedge mclk_i);
      if (i < 16) rd[i] = data_o; // read bits taken just before the edge
      prog_clk_o <= 1'b1;
      repeat (12) @(posedge mclk_i);
      prog_clk_o <= 1'b0;
    end
    drv <= 1'b0;
    prog_en_o <= 1'b0;
    repeat (12) @(posedge mclk_i);
  endtask : frame
endmodule : wmc_prog_model

// ---- test/wmc_wake_mode_config_bench.sv ----
module wmc_wake_mode_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, rst_i = 1, button_in_a_i = 0, button_in_b_i = 0, antenna_sense_pin_i = 0;
  logic write_voltage_ok_i = 1, multi_function_pin_i, data_pin_i, prog_enable_i;
  logic main_power_o, encoder_mode_o, transponder_mode_o, data_pin_o, data_pin_oe_o;
  logic multi_function_pin_o, multi_function_pin_oe_o, antenna_sense_en_o, antenna_drive_pin_o;
  logic osc_slow_o, osc_fast_o, vlow_select_o, mod_format_o, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0] osc_step_o, s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata;
  int errors = 0, n_compared = 0;
  // short debounce keeps each wake brief
  wmc_wake_mode_config #(.DEBOUNCE_CYCLES(8)) dut_u (.*);
  wmc_prog_model prog_u (.mclk_i, .dev_data_i(data_pin_o), .dev_oe_i(data_pin_oe_o),
    .prog_clk_o(multi_function_pin_i), .prog_en_o(prog_enable_i), .data_o(data_pin_i));
  initial forever #2 mclk_i = !mclk_i;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // write: both channels offered, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge mclk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    s_axi_araddr <= {24'h0, a};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge mclk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  function automatic logic pick(input int k);
    return k == 0 ? main_power_o : k == 1 ? encoder_mode_o : k == 2 ? transponder_mode_o : data_pin_oe_o;
  endfunction : pick
  // bounded wait on one output
  task automatic wait_sig(input int k, input logic v);
    for (int n = 0; n < 20000 && pick(k) !== v; n++) @(posedge mclk_i);
  endtask : wait_sig
  // tune decode: {slower, faster, step}
  function automatic logic [5:0] osc_exp(input logic [3:0] t);
    if (t == 4'h0) return 6'h00;
    if (!t[3]) return {2'b10, t};
    return {2'b01, 4'h0 - t};
  endfunction : osc_exp
  initial begin
    repeat (90000) @(posedge mclk_i);
    errors++;
    complete_run();
  end
  initial begin
    logic [31:0] d, fr;
    logic [1:0] r;
    logic [15:0] rd, cnt, u0, v;
    logic [7:0] cfg;
    void'($urandom(68));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    check(main_power_o, 0);
    check(antenna_sense_en_o, 1);
    axr(wmc_pkg::REG_STATUS, d, r);
    check(d[6], 0);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      if (i == 0) u0 = v;
      axw(8'(wmc_pkg::REG_USER0 + 4 * i), {16'h0, v});
      axr(8'(wmc_pkg::REG_USER0 + 4 * i), d, r);
      check(d[15:0], v);
    end
    prog_u.frame({1'b0, wmc_pkg::EE_USER0, 16'h0}, rd);
    check(rd, u0);
    axr(8'h40, d, r);
    check({r, d}, {wmc_pkg::RESP_SLVERR, 32'h0});
    cnt = 16'($urandom);
    prog_u.frame({1'b1, wmc_pkg::EE_CNT, cnt ^ (cnt >> 1)}, rd);
    prog_u.frame({1'b1, wmc_pkg::EE_SEM, wmc_pkg::SEM_IDLE}, rd);
    prog_u.frame({1'b0, wmc_pkg::EE_CNT, 16'h0}, rd);
    check(rd, cnt ^ (cnt >> 1));
    axr(wmc_pkg::REG_COUNTER, d, r);
    check(d[15:0], cnt);
    cfg = {3'($urandom), 1'b0, 4'($urandom)};
    axw(wmc_pkg::REG_CONFIG, {24'h0, cfg});
    button_in_a_i <= 1'b1;
    write_voltage_ok_i <= 1'b0;
    wait_sig(0, 1);
    check(main_power_o, 1);
    repeat (300) @(posedge mclk_i);
    write_voltage_ok_i <= 1'b1;
    wait_sig(1, 1);
    check(encoder_mode_o, 1);
    wait_sig(3, 1);
    button_in_a_i <= 1'b0;
    repeat (50) @(posedge mclk_i);
    for (int i = 31; i >= 0; i--) begin
      fr[i] = data_pin_o;
      repeat (100) @(posedge mclk_i);
    end
    check(fr, {cnt + 16'h1, 12'h0, 4'h1});
    wait_sig(0, 0);
    axr(wmc_pkg::REG_COUNTER, d, r);
    check(d[15:0], cnt + 16'h1);
    axr(wmc_pkg::REG_STATUS, d, r);
    check(d[6], 1);
    axr(wmc_pkg::REG_CONFIG, d, r);
    check(d[7:0], cfg);
    check({osc_slow_o, osc_fast_o, osc_step_o}, osc_exp(cfg[3:0]));
    antenna_sense_pin_i <= 1'b1;
    wait_sig(2, 1);
    check({encoder_mode_o, transponder_mode_o}, 2'b01);
    antenna_sense_pin_i <= 1'b0;
    wait_sig(0, 0);
    // antenna with button: button wins
    antenna_sense_pin_i <= 1'b1;
    button_in_b_i <= 1'b1;
    wait_sig(1, 1);
    check({encoder_mode_o, transponder_mode_o}, 2'b10);
    button_in_b_i <= 1'b0;
    wait_sig(2, 1);
    check(transponder_mode_o, 1);
    antenna_sense_pin_i <= 1'b0;
    wait_sig(0, 0);
    check(main_power_o, 0);
    for (int t = 0; t < 16; t++) begin
      cfg = {4'($urandom), 4'(t)};
      axw(wmc_pkg::REG_CONFIG, {24'h0, cfg});
      axw(wmc_pkg::REG_CTRL, 32'h2);
      repeat (40) @(posedge mclk_i);
      check({osc_slow_o, osc_fast_o, osc_step_o}, osc_exp(4'(t)));
      check(antenna_sense_en_o, !cfg[4]);
      check(multi_function_pin_oe_o, cfg[4] & cfg[7]);
      check({mod_format_o, vlow_select_o}, cfg[6:5]);
    end
    complete_run();
  end
endmodule : wmc_wake_mode_config_bench
